/* File: verilog/pidss_params.svh */
/*
 * offsets, field positions, reset values and timing counts of the
 * pid supervision block; assumes a 100 MHz clock.
 */
`ifndef PIDSS_PARAMS_SVH
`define PIDSS_PARAMS_SVH
// timing
`define PIDSS_CLK_NS 10
`define PIDSS_TENTH_NS 100000000
`define PIDSS_SEC_TENTHS 9'h00a
`define PIDSS_FULL_SCALE 8192
// register indices, byte address is index times four
`define PIDSS_R_CTRL 0
`define PIDSS_R_OFFSET 1
`define PIDSS_R_LAG 2
`define PIDSS_R_LOSS_LVL 3
`define PIDSS_R_LOSS_DLY 4
`define PIDSS_R_INT_LIM 5
`define PIDSS_R_IRESET 6
`define PIDSS_R_MARGIN 7
`define PIDSS_R_SLEEP_LVL 8
`define PIDSS_R_SLEEP_DLY 9
`define PIDSS_R_WAKE_LVL 10
`define PIDSS_R_WAKE_DLY 11
`define PIDSS_R_FB_MAX 12
`define PIDSS_R_STATUS 13
`define PIDSS_R_IRQ_STAT 14
`define PIDSS_R_IRQ_MASK 15
`define PIDSS_NCFG 13
// fields of the control register
`define PIDSS_CTRL_DIR 0
`define PIDSS_CTRL_MODE 2:1
`define PIDSS_CTRL_FBMIN 15:6
// reset values
`define PIDSS_RST_ZERO 16'h0000
`define PIDSS_RST_FB_MAX 16'h03e7
`endif

/* File: verilog/pidss_pkg.sv */
/*
 * types of the pid supervision block; assumes pidss_params.svh
 * is compiled alongside.
 */
package pidss_pkg;
  // classic wishbone request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pidss_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pidss_wb_rsp_t;
  // sleep state, one-hot
  typedef enum logic [1:0] {
    PIDSS_AWAKE = 2'b01,
    PIDSS_ASLEEP = 2'b10
  } pidss_sleep_t;
  // feedback loss handling
  typedef enum logic [1:0] {
    PIDSS_LOSS_OFF = 2'b00,
    PIDSS_LOSS_CONT = 2'b01,
    PIDSS_LOSS_STOP = 2'b10
  } pidss_loss_t;
endpackage

/* File: verilog/pidss_top.sv */
/*
 * pid supervision: output offset, lag filter, integrator limit and
 * reset, feedback loss, sleep and wake, feedback scaling.
 * assumes pid core signals on the same clock, q13 (8192 = 100 %).
 */
`include "pidss_params.svh"
// What this block does
// - adds an offset of 0 to 109 percent to the pid output.
// - the offset is added when direction is 0, subtracted when 1.
// - the output passes a lag filter whose time sets its update interval.
// - mode 1 raises the loss indication and keeps running, mode 0 disables.
// - mode 2 raises the loss indication and stops the drive.
// - loss is set point minus feedback beyond the loss level of 0 to 100.
// - loss is declared only after the loss delay has passed.
// - the integrator is clamped to a limit of 0 to 109 percent.
// - reset setting 0 never clears the integrator.
// - setting 1 to 30 clears it that many seconds after reaching target and stops.
// - after that the drive runs again once the error exceeds the margin.
// - below the sleep level for longer than the sleep delay, it goes to sleep.
// - asleep, it wakes when the frequency exceeds the wake level for the wake delay.
// - feedback is scaled linearly between minimum and maximum levels.
module pidss_top
  import pidss_pkg::*;
#(
  parameter int TICK_CYCLES = `PIDSS_TENTH_NS / `PIDSS_CLK_NS,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire pidss_wb_req_t wb_req,
  output pidss_wb_rsp_t wb_rsp,
  input wire logic signed [DW-1:0] set_point,
  input wire logic signed [DW-1:0] feedback,
  input wire logic signed [DW:0] pid_in,
  input wire logic signed [DW:0] integ_in,
  input wire logic [15:0] pid_freq,
  output logic signed [DW:0] pid_out,
  output logic signed [DW:0] integ_out,
  output logic integ_clear,
  output logic signed [10:0] fb_scaled,
  output logic [15:0] freq_cmd,
  output logic drive_stop,
  output logic feedback_loss_indication,
  output logic pid_sleep,
  output logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // percent to q13
  function automatic logic [13:0] pct2q(input logic [6:0] p);
    logic [19:0] w;
    w = {13'h0000, p} * 20'h0_2000;
    return 14'(w / 20'h0_0064);
  endfunction
  // writable bits of each register
  function automatic logic [15:0] reg_mask(input int i);
    case (i)
      `PIDSS_R_CTRL: reg_mask = 16'hffc7;
      `PIDSS_R_OFFSET, `PIDSS_R_LOSS_LVL, `PIDSS_R_INT_LIM,
      `PIDSS_R_MARGIN: reg_mask = 16'h007f;
      `PIDSS_R_LAG, `PIDSS_R_IRESET: reg_mask = 16'h001f;
      `PIDSS_R_LOSS_DLY, `PIDSS_R_SLEEP_DLY,
      `PIDSS_R_WAKE_DLY: reg_mask = 16'h00ff;
      `PIDSS_R_FB_MAX: reg_mask = 16'h03ff;
      default: reg_mask = 16'hffff;
    endcase
  endfunction

  logic [15:0] cfg [0:`PIDSS_NCFG-1];
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [31:0] tick_cnt;
  logic tick;
  logic [4:0] lag_cnt;
  logic signed [DW:0] adj;
  logic signed [DW+1:0] diff;
  logic signed [DW:0] lim;
  logic signed [DW:0] err;
  logic [DW:0] abs_err;
  logic loss_cond;
  logic reach;
  logic ireset_stop;
  pidss_sleep_t state;
  pidss_sleep_t next_state;
  logic [3:0] cond;
  logic [3:0] done;
  logic [8:0] limit [0:3];
  logic [8:0] t_cnt [0:3];
  logic [3:0] ev;
  logic [3:0] next_stat;
  logic take;
  logic hit;
  logic [3:0] idx;
  logic [15:0] rd;

  // field views
  logic dir;
  logic [1:0] mode;
  logic [13:0] off_q;
  logic [4:0] lag_t;
  logic [4:0] ireset_s;
  assign dir = cfg[`PIDSS_R_CTRL][`PIDSS_CTRL_DIR];
  assign mode = cfg[`PIDSS_R_CTRL][`PIDSS_CTRL_MODE];
  assign off_q = pct2q(cfg[`PIDSS_R_OFFSET][6:0]);
  assign lag_t = cfg[`PIDSS_R_LAG][4:0];
  assign ireset_s = cfg[`PIDSS_R_IRESET][4:0];

  // bus decode, one wait-free answer per request
  assign take = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
  assign idx = wb_req.adr[5:2];
  assign hit = wb_req.adr[7:6] == 2'b00;

  // configuration store with byte lanes
  always_ff @(posedge clk) begin
    for (int i = 0; i < `PIDSS_NCFG; i++) begin
      if (reset) begin
        cfg[i] <= (i == `PIDSS_R_FB_MAX) ? `PIDSS_RST_FB_MAX : `PIDSS_RST_ZERO;
      end else if (take && hit && wb_req.we && idx == 4'(i)) begin
        if (wb_req.sel[0]) cfg[i][7:0] <= wb_req.dat[7:0] & 8'(reg_mask(i));
        if (wb_req.sel[1]) cfg[i][15:8] <= wb_req.dat[15:8] & 8'(reg_mask(i) >> 8);
      end
    end
  end

  // read mux
  always_comb begin
    rd = 16'h0000;
    if (idx < 4'(`PIDSS_NCFG)) rd = cfg[idx];
    else if (idx == 4'(`PIDSS_R_STATUS))
      rd = {12'h000, pid_sleep, ireset_stop, drive_stop, feedback_loss_indication};
    else if (idx == 4'(`PIDSS_R_IRQ_STAT)) rd = {12'h000, irq_stat};
    else rd = {12'h000, irq_mask};
  end

  // answer, unmapped reads give zero
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= take;
      wb_rsp.dat <= (take && hit) ? {16'h0000, rd} : 32'h0000_0000;
    end
  end

  // tenth-second tick
  always_ff @(posedge clk) begin
    if (reset || tick) tick_cnt <= 32'h0000_0000;
    else tick_cnt <= tick_cnt + 32'h0000_0001;
  end
  assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

  // offset with direction
  assign adj = dir ? pid_in - $signed({3'b000, off_q})
                   : pid_in + $signed({3'b000, off_q});
  assign diff = {adj[DW], adj} - {pid_out[DW], pid_out};

  // lag filter: half step toward target every lag interval
  always_ff @(posedge clk) begin
    if (reset) begin
      pid_out <= '0;
      lag_cnt <= 5'h00;
    end else if (lag_t == 5'h00) begin
      pid_out <= adj;
      lag_cnt <= 5'h00;
    end else if (tick) begin
      if (lag_cnt >= lag_t - 5'h01) begin
        pid_out <= pid_out + (DW+1)'(diff >>> 1);
        lag_cnt <= 5'h00;
      end else begin
        lag_cnt <= lag_cnt + 5'h01;
      end
    end
  end

  // error and its comparisons
  assign err = {set_point[DW-1], set_point} - {feedback[DW-1], feedback};
  assign abs_err = err[DW] ? (DW+1)'(-err) : err;
  assign loss_cond = mode != PIDSS_LOSS_OFF &&
    err > $signed({3'b000, pct2q(cfg[`PIDSS_R_LOSS_LVL][6:0])});
  assign reach = abs_err <= (DW+1)'(cfg[`PIDSS_R_MARGIN][6:0]);
  assign lim = $signed({3'b000, pct2q(cfg[`PIDSS_R_INT_LIM][6:0])});

  // timer conditions and limits in tenths
  assign cond[0] = loss_cond;
  assign limit[0] = {1'b0, cfg[`PIDSS_R_LOSS_DLY][7:0]};
  assign cond[1] = ireset_s != 5'h00 && reach && !ireset_stop;
  assign limit[1] = 9'({4'h0, ireset_s} * `PIDSS_SEC_TENTHS);
  assign cond[2] = state == PIDSS_AWAKE && pid_freq < cfg[`PIDSS_R_SLEEP_LVL];
  assign limit[2] = {1'b0, cfg[`PIDSS_R_SLEEP_DLY][7:0]} + 9'h001;
  assign cond[3] = state == PIDSS_ASLEEP && pid_freq > cfg[`PIDSS_R_WAKE_LVL];
  assign limit[3] = {1'b0, cfg[`PIDSS_R_WAKE_DLY][7:0]};

  // delay timers
  for (genvar g = 0; g < 4; g++) begin : g_tmr
    always_ff @(posedge clk) begin
      if (reset || !cond[g]) t_cnt[g] <= 9'h000;
      else if (tick && t_cnt[g] != 9'h1ff) t_cnt[g] <= t_cnt[g] + 9'h001;
    end
    assign done[g] = cond[g] && t_cnt[g] >= limit[g];
  end

  // loss indication and stop
  always_ff @(posedge clk) begin
    if (reset) begin
      feedback_loss_indication <= 1'b0;
      drive_stop <= 1'b0;
    end else begin
      feedback_loss_indication <= done[0];
      drive_stop <= (done[0] && mode == PIDSS_LOSS_STOP)
        || done[1] || (ireset_stop && reach);
    end
  end

  // integrator reset latch and clamp
  always_ff @(posedge clk) begin
    if (reset) begin
      ireset_stop <= 1'b0;
      integ_clear <= 1'b0;
      integ_out <= '0;
    end else begin
      integ_clear <= done[1];
      if (done[1]) ireset_stop <= 1'b1;
      else if (!reach || ireset_s == 5'h00) ireset_stop <= 1'b0;
      if (done[1] || ireset_stop) integ_out <= '0;
      else if (integ_in > lim) integ_out <= lim;
      else if (integ_in < -lim) integ_out <= -lim;
      else integ_out <= integ_in;
    end
  end

  // sleep and wake
  always_comb begin
    case (state)
      PIDSS_AWAKE: next_state = done[2] ? PIDSS_ASLEEP : PIDSS_AWAKE;
      PIDSS_ASLEEP: next_state = done[3] ? PIDSS_AWAKE : PIDSS_ASLEEP;
      default: next_state = PIDSS_AWAKE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= PIDSS_AWAKE;
      pid_sleep <= 1'b0;
      freq_cmd <= 16'h0000;
    end else begin
      state <= next_state;
      pid_sleep <= next_state == PIDSS_ASLEEP;
      freq_cmd <= (pid_sleep || drive_stop) ? 16'h0000 : pid_freq;
    end
  end

  // feedback scaling
  logic signed [10:0] span;
  logic signed [14:0] fbc;
  logic signed [25:0] prod;
  assign span = $signed({1'b0, cfg[`PIDSS_R_FB_MAX][9:0]})
    - $signed({1'b0, cfg[`PIDSS_R_CTRL][`PIDSS_CTRL_FBMIN]});
  assign fbc = feedback < 0 ? 15'sh0000
    : (feedback > `PIDSS_FULL_SCALE) ? 15'sh2000 : 15'(feedback);
  assign prod = span * fbc;
  always_ff @(posedge clk) begin
    if (reset) fb_scaled <= 11'sh000;
    else fb_scaled <= $signed({1'b0, cfg[`PIDSS_R_CTRL][`PIDSS_CTRL_FBMIN]})
      + 11'(prod >>> 13);
  end

  // interrupt status, set wins over clear
  assign ev = {state == PIDSS_ASLEEP && done[3], state == PIDSS_AWAKE && done[2],
    done[1], done[0] && !feedback_loss_indication};
  always_comb begin
    next_stat = irq_stat;
    if (take && hit && wb_req.we && wb_req.sel[0] && idx == 4'(`PIDSS_R_IRQ_STAT))
      next_stat = irq_stat & ~wb_req.dat[3:0];
    next_stat = next_stat | ev;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      if (take && hit && wb_req.we && wb_req.sel[0] && idx == 4'(`PIDSS_R_IRQ_MASK))
        irq_mask <= wb_req.dat[3:0];
      irq <= |(next_stat & irq_mask);
    end
  end

  // checks
  sequence s_go_sleep;
    pid_sleep ##1 freq_cmd == 16'h0000;
  endsequence
  sequence s_stopped;
    integ_clear && drive_stop ##1 integ_out == '0;
  endsequence
  AST_OFFSET_POS: assert property (
    lag_t == 5'h00 && !dir |=> pid_out == $past(pid_in) + $signed({3'b000, $past(off_q)}))
    else $error("positive offset not applied");
  AST_OFFSET_NEG: assert property (
    lag_t == 5'h00 && dir |=> pid_out == $past(pid_in) - $signed({3'b000, $past(off_q)}))
    else $error("negative offset not applied");
  AST_LAG_HOLD: assert property (
    lag_t != 5'h00 && !tick |=> $stable(pid_out))
    else $error("filtered output moved between updates");
  AST_LOSS_OFF: assert property (
    mode == PIDSS_LOSS_OFF |=> !feedback_loss_indication)
    else $error("loss raised while detection disabled");
  AST_LOSS_STOP: assert property (
    done[0] && mode == PIDSS_LOSS_STOP |=> drive_stop && feedback_loss_indication)
    else $error("loss in stop mode did not stop");
  AST_LOSS_LVL: assert property (
    !loss_cond |=> !feedback_loss_indication)
    else $error("loss raised without error beyond level");
  AST_LOSS_DLY: assert property (
    $rose(feedback_loss_indication) |-> $past(t_cnt[0]) >= $past(limit[0]))
    else $error("loss raised before delay");
  AST_INT_LIM: assert property (
    1'b1 |=> integ_out <= $past(lim) && integ_out >= -$past(lim))
    else $error("integrator beyond limit");
  AST_IRESET_OFF: assert property (
    ireset_s == 5'h00 |=> !integ_clear)
    else $error("integrator cleared while disabled");
  AST_IRESET_STOP: assert property (
    done[1] |=> s_stopped)
    else $error("integrator reset did not clear and stop");
  AST_RESTART: assert property (
    ireset_stop && !reach |=> !ireset_stop)
    else $error("no restart after error beyond margin");
  AST_SLEEP: assert property (
    state == PIDSS_AWAKE && done[2] |=> s_go_sleep)
    else $error("sleep not entered");
  AST_WAKE: assert property (
    state == PIDSS_ASLEEP && done[3] |=> !pid_sleep [*2])
    else $error("wake not taken");
  AST_TMR_RESTART: assert property (
    !cond[2] |=> t_cnt[2] == 9'h000)
    else $error("sleep timer not restarted");
endmodule

/* File: dv/testbench.sv */
/*
 * self-checking bench for pidss_top: wishbone tasks and supervision scenarios.
 * assumes TICK_CYCLES of 10, so one tenth of a second is 10 clocks.
 */
module testbench import pidss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, v;
  pidss_wb_req_t wbq;
  pidss_wb_rsp_t wbr;
  logic signed [15:0] sp, fb;
  logic signed [16:0] pin, iin, pout, iout;
  logic [15:0] frq, fcmd;
  logic signed [10:0] fbs;
  logic iclr, stp, fli, slp, irq;
  logic [31:0] q;
  int n_mismatch, cmp_count, i, m;

  // design under test with a short tenth
  pidss_top #(.TICK_CYCLES(10)) i_dut (
    .clk(clk), .reset(reset), .wb_req(wbq), .wb_rsp(wbr),
    .set_point(sp), .feedback(fb), .pid_in(pin), .integ_in(iin), .pid_freq(frq),
    .pid_out(pout), .integ_out(iout), .integ_clear(iclr), .fb_scaled(fbs),
    .freq_cmd(fcmd), .drive_stop(stp), .feedback_loss_indication(fli),
    .pid_sleep(slp), .irq(irq)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // verdict and end of run
  task stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // classic single wishbone cycle, held until ack is sampled
  task wb(input logic we, input int r, input logic [15:0] d);
    int k;
    @(posedge clk);
    wbq <= '{1'b1, 1'b1, we, 4'h3, 8'(r * 4), {16'h0000, d}};
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (wbr.ack === 1'b1) break;
    end
    q = wbr.dat;
    wbq <= '0;
    if (k == 20) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  // synchronous reset for 8 cycles
  task rst;
    @(posedge clk);
    reset <= 1'b1;
    tick(8);
    reset <= 1'b0;
  endtask

  // main sequence
  initial begin
    reset = 1'b1;
    wbq = '0;
    sp = 16'h0000;
    fb = 16'h0000;
    pin = 17'h0_0000;
    iin = 17'h0_0000;
    frq = 16'h0bb8;
    n_mismatch = 0;
    cmp_count = 0;
    tick(8);
    reset <= 1'b0;
    // reset values and an unmapped place
    wb(0, 0, 16'h0000);
    chk("ctrl", q, 0);
    wb(0, 12, 16'h0000);
    chk("fb_max", q, 999);
    wb(1, 16, 16'h1234);
    wb(0, 16, 16'h0000);
    chk("unmapped", q, 0);
    // scaling between min and max
    fb <= 16'h1000;
    tick(3);
    chk("fb_scaled full", fbs, 999 * 4096 / 8192);
    wb(1, 12, 16'h0064);
    wb(1, 0, 16'h0c80);
    tick(3);
    chk("fb_scaled", fbs, 50 + 50 * 4096 / 8192);
    // offset at both polarities and the top of the range
    pin <= 17'h0_03e8;
    wb(1, 0, 16'h0000);
    wb(1, 1, 16'h006d);
    tick(3);
    chk("offset pos", pout, 1000 + 109 * 8192 / 100);
    wb(1, 1, 16'h000a);
    wb(1, 0, 16'h0001);
    tick(3);
    chk("offset neg", pout, 1000 - 819);
    // lag filter halves the distance every two tenths
    wb(1, 0, 16'h0000);
    wb(1, 1, 16'h0000);
    tick(3);
    wb(1, 2, 16'h0002);
    pin <= 17'h0_1f40;
    for (i = 0; i < 40 && pout === 17'sh0_03e8; i++) tick(1);
    chk("lag step", pout, 4500);
    for (i = 0; i < 40 && pout === 17'sh0_1194; i++) tick(1);
    chk("lag next", pout, 6250);
    chk("lag period", i, 20);
    // every loss mode with a clear loss
    for (m = 0; m < 4; m++) begin
      rst();
      sp <= 16'h1000;
      fb <= 16'h0000;
      wb(1, 3, 16'h000a);
      wb(1, 0, 16'(m << 1));
      tick(4);
      chk("loss", fli, m != 0);
      chk("loss stop", stp, m == 2);
    end
    // error at the level is no loss, then a delayed loss
    rst();
    fb <= 16'h0ccd;
    wb(1, 3, 16'h000a);
    wb(1, 4, 16'h0003);
    wb(1, 0, 16'h0004);
    tick(40);
    chk("loss at level", fli, 0);
    fb <= 16'h0000;
    tick(15);
    chk("loss early", fli, 0);
    for (i = 0; i < 40 && fli !== 1'b1; i++) tick(1);
    chk("loss late", fli, 1);
    chk("loss stops", stp, 1);
    // sticky status, mask and clear
    wb(0, 14, 16'h0000);
    chk("irq status", q[0], 1);
    wb(1, 15, 16'h0000);
    tick(2);
    v = irq;
    wb(1, 15, 16'h000f);
    tick(2);
    chk("irq masked", v, 0);
    chk("irq mask", irq, 1);
    fb <= 16'h1000;
    tick(4);
    wb(1, 14, 16'h000f);
    wb(0, 14, 16'h0000);
    chk("irq cleared", q[3:0], 0);
    tick(2);
    chk("irq low", irq, 0);
    // integrator clamp at 50 percent
    rst();
    wb(1, 5, 16'h0032);
    iin <= 17'h0_1770;
    tick(3);
    chk("clamp hi", iout, 4096);
    iin <= -17'sh0_1770;
    tick(3);
    chk("clamp lo", iout, -4096);
    iin <= 17'h0_03e8;
    tick(3);
    chk("clamp pass", iout, 1000);
    // integrator reset off, then after one second
    sp <= 16'h03e8;
    fb <= 16'h03e8;
    v = 1'b0;
    repeat (150) begin
      tick(1);
      v = v | (iclr === 1'b1);
    end
    chk("no clear", v, 0);
    wb(1, 7, 16'h000a);
    wb(1, 6, 16'h0001);
    for (i = 0; i < 150 && iclr !== 1'b1; i++) tick(1);
    chk("clear", iclr, 1);
    chk("clear wait", i >= 90, 1);
    tick(2);
    chk("reset stop", stp, 1);
    chk("integ zero", iout, 0);
    fb <= 16'h03f2;
    tick(5);
    chk("in margin", stp, 1);
    fb <= 16'h03f3;
    tick(4);
    chk("restart", stp, 0);
    // sleep timer restarts when the condition drops
    rst();
    wb(1, 8, 16'h03e8);
    wb(1, 9, 16'h0001);
    wb(1, 10, 16'h07d0);
    wb(1, 11, 16'h0002);
    // one tenth counted, then the condition drops before the second
    frq <= 16'h01f4;
    tick(10);
    frq <= 16'h03e8;
    tick(2);
    frq <= 16'h01f4;
    tick(8);
    chk("sleep restart", slp, 0);
    for (i = 0; i < 60 && slp !== 1'b1; i++) tick(1);
    chk("sleep", slp, 1);
    tick(1);
    chk("sleep cmd", fcmd, 0);
    // wake needs the level exceeded for the wake delay
    frq <= 16'h07d1;
    tick(8);
    chk("wake early", slp, 1);
    for (i = 0; i < 60 && slp !== 1'b0; i++) tick(1);
    chk("wake", slp, 0);
    tick(2);
    chk("wake cmd", fcmd, 16'h07d1);
    stop_test();
  end
endmodule
